// [verilog/pmac_map.svh]
`ifndef PMAC_MAP_SVH
`define PMAC_MAP_SVH
`define PMAC_NCLS 4
`define PMAC_ORD_MAX 5'h1A
`define PMAC_CLK_HZ 25000000
`define PMAC_DIM_S 10
`define PMAC_DIM_CYC (`PMAC_DIM_S * `PMAC_CLK_HZ)
`define PMAC_ADJ_CYC 16'h0010
`define PMAC_FLOW_LO 16'h0064
`define PMAC_FLOW_HI 16'h0190
`define PMAC_SEQ_START 5'h1F
`define PMAC_SEQ_SLOT 16'h0100
`define PMAC_AVG_MAX 4'h8
`define PMAC_BLINK_BIT 23
`endif

// [verilog/pmac_pkg.sv]
`default_nettype none
package pmac_pkg;
  typedef enum logic [5:0] {
    PMAC_IDLE = 6'b000001,
    PMAC_ADJ = 6'b000010,
    PMAC_MEAS = 6'b000100,
    PMAC_WAIT = 6'b001000,
    PMAC_SHOW = 6'b010000,
    PMAC_PAUSE = 6'b100000
  } pmac_state_t;
  typedef enum logic [1:0] {
    PMAC_TIMED = 2'h0,
    PMAC_EXT = 2'h1,
    PMAC_KEY = 2'h2
  } pmac_trig_t;
  typedef enum logic [1:0] {
    PMAC_SERIAL = 2'h0,
    PMAC_CAN = 2'h1,
    PMAC_SENSE = 2'h2
  } pmac_link_t;
endpackage : pmac_pkg
`default_nettype wire

// [verilog/pmac_class_eval.sv]
`default_nettype none
`include "pmac_map.svh"
module pmac_class_eval
(
  // clock
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // result stream
  input wire logic load,
  input wire logic [4:0] value,
  input wire logic [3:0] avg_n,
  // threshold
  input wire logic [4:0] thresh,
  // verdicts
  output logic above,
  output logic below,
  output logic active
);
  // last eight samples kept; mean over the newest avg_n of them
  logic [4:0] hist_q [0:7];
  logic [3:0] n_q;
  logic [3:0] cnt;
  logic [7:0] sum;
  logic [7:0] mean;
  integer i;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < 8; i = i + 1)
        hist_q[i] <= 5'h00;
      n_q <= 4'h0;
    end
    else if (ce && load)
    begin
      for (i = 1; i < 8; i = i + 1)
        hist_q[i] <= hist_q[i-1];
      hist_q[0] <= value;
      if (n_q < 4'h8)
        n_q <= n_q + 4'h1;
    end
  end

  // summing the live history lets the window shrink without a stale sum
  always_comb
  begin
    cnt = (n_q < avg_n) ? n_q : avg_n;
    sum = 8'h00;
    for (int k = 0; k < 8; k++)
      if (k < cnt)
        sum = sum + {3'h0, hist_q[k]};
    mean = (cnt == 4'h0) ? 8'h00 : sum / {4'h0, cnt};
  end

  assign active = (thresh != 5'h00);
  assign above = active && (mean > {3'h0, thresh});
  assign below = !active || (mean < {3'h0, thresh});
endmodule : pmac_class_eval
`default_nettype wire

// [verilog/pmac_ctrl.sv]
`default_nettype none
`include "pmac_map.svh"
module pmac_ctrl
#(
  parameter int DIM_CYC = `PMAC_DIM_CYC,
  // blink divider tap, at most 23
  parameter int BLINK_BIT = `PMAC_BLINK_BIT
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // operator and plant
  input wire logic start_n_pin,
  input wire logic key_press,
  input wire logic key_ack,
  input wire logic activity,
  // configuration
  input wire logic [1:0] trig_mode,
  input wire logic [15:0] meas_cyc,
  input wire logic [15:0] wait_cyc,
  input wire logic [15:0] pause_cyc,
  input wire logic cleanup_watch,
  input wire logic ack_hold,
  input wire logic [3:0] avg_count,
  input wire logic [19:0] thresholds,
  input wire logic [1:0] out_class,
  input wire logic class_sequence,
  input wire logic alt_standard,
  input wire logic preset_flow_select,
  input wire logic [15:0] preset_flow,
  input wire logic backlight_continuous,
  input wire logic [1:0] link_mode,
  input wire logic can_present,
  // measurement front end
  input wire logic result_ready,
  input wire logic [19:0] result_ord,
  input wire logic [4:0] ord_38_70,
  input wire logic [15:0] measured_flow,
  // outputs
  output logic laser_adjust,
  output logic measuring,
  output logic result_shown,
  output logic alarm,
  output logic red_lamp,
  output logic exclaim,
  output logic [4:0] current_code,
  output logic [15:0] flow_used,
  output logic flow_low_blink,
  output logic flow_high_blink,
  output logic backlight,
  output logic route_serial,
  output logic route_can
);
  pmac_pkg::pmac_state_t st_q;
  logic [15:0] tmr_q;
  logic s1_q, s2_q, s3_q, in_act_q;
  logic key_run_q;
  logic [19:0] folded;
  logic [3:0] above_v, below_v, act_v;
  logic [4:0] seq_idx_q;
  logic [15:0] seq_tmr_q;
  logic [31:0] dim_q;
  logic [23:0] blink_q;
  logic load_q;
  logic all_zero;
  logic cond;

  // three-stage sync; change accepted when stage 2 and 3 agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      in_act_q <= 1'b0;
    end
    else if (ce)
    begin
      s1_q <= start_n_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        in_act_q <= !s3_q;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      key_run_q <= 1'b0;
    else if (ce && trig_mode != pmac_pkg::PMAC_KEY)
      key_run_q <= 1'b0;
    else if (ce && key_press)
      key_run_q <= !key_run_q;
  end

  // sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= pmac_pkg::PMAC_IDLE;
      tmr_q <= 16'h0000;
    end
    else if (ce)
    begin
      tmr_q <= tmr_q + 16'h0001;
      case (st_q)
        pmac_pkg::PMAC_IDLE:
        begin
          tmr_q <= 16'h0000;
          if ((trig_mode == pmac_pkg::PMAC_TIMED) ||
              (trig_mode == pmac_pkg::PMAC_EXT && !in_act_q) ||
              (trig_mode == pmac_pkg::PMAC_KEY && key_run_q))
            st_q <= pmac_pkg::PMAC_ADJ;
        end
        pmac_pkg::PMAC_ADJ:
          if (tmr_q >= `PMAC_ADJ_CYC - 16'h0001)
          begin
            tmr_q <= 16'h0000;
            st_q <= pmac_pkg::PMAC_MEAS;
          end
        pmac_pkg::PMAC_MEAS:
          if (trig_mode == pmac_pkg::PMAC_EXT)
          begin
            if (in_act_q)
              st_q <= pmac_pkg::PMAC_IDLE;
          end
          else if (trig_mode == pmac_pkg::PMAC_KEY)
          begin
            if (!key_run_q)
              st_q <= pmac_pkg::PMAC_IDLE;
            else if (result_ready)
            begin
              tmr_q <= 16'h0000;
              st_q <= pmac_pkg::PMAC_SHOW;
            end
          end
          else if (tmr_q >= meas_cyc - 16'h0001)
          begin
            tmr_q <= 16'h0000;
            st_q <= pmac_pkg::PMAC_WAIT;
          end
        pmac_pkg::PMAC_WAIT:
          // back to adjust in timed mode, otherwise to idle, so the gap is exactly wait_cyc
          if (tmr_q + 16'h0001 >= wait_cyc)
          begin
            tmr_q <= 16'h0000;
            if (trig_mode == pmac_pkg::PMAC_TIMED)
              st_q <= pmac_pkg::PMAC_ADJ;
            else
              st_q <= pmac_pkg::PMAC_IDLE;
          end
        pmac_pkg::PMAC_SHOW:
        begin
          tmr_q <= 16'h0000;
          st_q <= pmac_pkg::PMAC_PAUSE;
        end
        pmac_pkg::PMAC_PAUSE:
          if (!key_run_q)
            st_q <= pmac_pkg::PMAC_IDLE;
          else if (tmr_q >= pause_cyc)
          begin
            tmr_q <= 16'h0000;
            st_q <= pmac_pkg::PMAC_ADJ;
          end
        default:
          st_q <= pmac_pkg::PMAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      laser_adjust <= 1'b0;
      measuring <= 1'b0;
      result_shown <= 1'b0;
    end
    else if (ce)
    begin
      laser_adjust <= (st_q == pmac_pkg::PMAC_ADJ);
      measuring <= (st_q == pmac_pkg::PMAC_MEAS);
      result_shown <= (st_q == pmac_pkg::PMAC_SHOW) ||
                      (st_q == pmac_pkg::PMAC_PAUSE);
    end
  end

  // class 3 is the 21 um channel; alternate standard keeps the larger
  always_comb
  begin
    folded = result_ord;
    if (alt_standard && ord_38_70 > result_ord[19:15])
      folded[19:15] = ord_38_70;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      load_q <= 1'b0;
    else if (ce)
      load_q <= result_ready && (folded != 20'h00000);
  end

  logic [19:0] res_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      res_q <= 20'h00000;
    else if (ce && result_ready)
      res_q <= folded;
  end

  // one threshold vector feeds both alarm types
  genvar g;
  generate
    for (g = 0; g < `PMAC_NCLS; g = g + 1)
    begin : g_cls
      pmac_class_eval u_eval
      (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load(load_q),
        .value(res_q[g*5 +: 5]),
        .avg_n((avg_count == 4'h0) ? 4'h1 :
               (avg_count > `PMAC_AVG_MAX) ? `PMAC_AVG_MAX : avg_count),
        .thresh(thresholds[g*5 +: 5]),
        .above(above_v[g]),
        .below(below_v[g]),
        .active(act_v[g])
      );
    end
  endgenerate

  // evaluation sees the mean one cycle after the sample loads
  logic eval_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      eval_q <= 1'b0;
    else if (ce)
      eval_q <= load_q;
  end

  always_comb
  begin
    if (cleanup_watch)
      cond = &below_v;
    else
      cond = |above_v;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      alarm <= 1'b0;
    else if (ce)
    begin
      if (act_v == 4'h0)
        alarm <= 1'b0;
      else if (eval_q)
      begin
        if (cond)
          alarm <= 1'b1;
        else if (!ack_hold)
          alarm <= 1'b0;
      end
      else if (ack_hold && key_ack)
        alarm <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      red_lamp <= 1'b0;
      exclaim <= 1'b0;
    end
    else if (ce)
    begin
      red_lamp <= alarm;
      exclaim <= alarm;
    end
  end

  // current output: start marker, four classes, one pause slot
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seq_idx_q <= 5'h00;
      seq_tmr_q <= 16'h0000;
      current_code <= 5'h00;
    end
    else if (ce)
    begin
      if (class_sequence)
      begin
        seq_tmr_q <= seq_tmr_q + 16'h0001;
        if (seq_tmr_q >= `PMAC_SEQ_SLOT - 16'h0001)
        begin
          seq_tmr_q <= 16'h0000;
          seq_idx_q <= (seq_idx_q == 5'h05) ? 5'h00 : seq_idx_q + 5'h01;
        end
        if (seq_idx_q == 5'h00)
          current_code <= `PMAC_SEQ_START;
        else if (seq_idx_q == 5'h05)
          current_code <= 5'h00;
        else
          current_code <= res_q[(seq_idx_q - 5'h01)*5 +: 5];
      end
      else
      begin
        seq_idx_q <= 5'h00;
        seq_tmr_q <= 16'h0000;
        // clamp: ordinals above 26 would exceed 20 mA
        if (res_q[out_class*5 +: 5] > `PMAC_ORD_MAX)
          current_code <= `PMAC_ORD_MAX;
        else
          current_code <= res_q[out_class*5 +: 5];
      end
    end
  end

  // flow source and range markers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flow_used <= 16'h0000;
      flow_low_blink <= 1'b0;
      flow_high_blink <= 1'b0;
      blink_q <= 24'h000000;
    end
    else if (ce)
    begin
      blink_q <= blink_q + 24'h000001;
      flow_used <= preset_flow_select ? preset_flow : measured_flow;
      flow_low_blink <= (measured_flow < `PMAC_FLOW_LO) &&
                        blink_q[BLINK_BIT];
      flow_high_blink <= (measured_flow > `PMAC_FLOW_HI) &&
                         blink_q[BLINK_BIT];
    end
  end

  // backlight dimming
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dim_q <= 32'h00000000;
      backlight <= 1'b1;
    end
    else if (ce)
    begin
      if (activity || key_press || key_ack)
        dim_q <= 32'h00000000;
      else if (dim_q < DIM_CYC[31:0])
        dim_q <= dim_q + 32'h00000001;
      backlight <= backlight_continuous || (dim_q < DIM_CYC[31:0]);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      route_serial <= 1'b0;
      route_can <= 1'b0;
    end
    else if (ce)
    begin
      route_serial <= (link_mode == pmac_pkg::PMAC_SERIAL) ||
                      (link_mode == pmac_pkg::PMAC_SENSE && !can_present);
      route_can <= (link_mode == pmac_pkg::PMAC_CAN) ||
                   (link_mode == pmac_pkg::PMAC_SENSE && can_present);
    end
  end

  // duration floor is the configuring party's duty; not checked

  property p_lamp;
    @(posedge clk) disable iff (rst)
    ce ##1 ce |-> red_lamp == $past(alarm) && exclaim == red_lamp;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp not following alarm");

  property p_off;
    @(posedge clk) disable iff (rst)
    ce && act_v == 4'h0 |=> !alarm;
  endproperty
  a_off: assert property (p_off) else $error("alarm with zero thresholds");

  property p_rise;
    @(posedge clk) disable iff (rst)
    ce && $rose(alarm) |-> $past(eval_q) && $past(cond);
  endproperty
  a_rise: assert property (p_rise) else $error("alarm rose without eval");

  property p_hold;
    @(posedge clk) disable iff (rst)
    ce && ack_hold && alarm && !key_ack && !eval_q && act_v != 4'h0
      |=> alarm;
  endproperty
  a_hold: assert property (p_hold) else $error("held alarm dropped");

  property p_exceed;
    @(posedge clk) disable iff (rst)
    ce && eval_q && !cleanup_watch && |above_v && act_v != 4'h0 |=> alarm;
  endproperty
  a_exceed: assert property (p_exceed) else $error("exceed missed");

  property p_clean;
    @(posedge clk) disable iff (rst)
    ce && eval_q && cleanup_watch && &below_v && act_v != 4'h0 |=> alarm;
  endproperty
  a_clean: assert property (p_clean) else $error("cleanup missed");

  property p_zero;
    @(posedge clk) disable iff (rst)
    ce && result_ready && folded == 20'h00000 |=> !load_q;
  endproperty
  a_zero: assert property (p_zero) else $error("zero result loaded");

  property p_clamp;
    @(posedge clk) disable iff (rst)
    ce && !class_sequence |=> current_code <= `PMAC_ORD_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("code above 26");

  property p_ext;
    @(posedge clk) disable iff (rst)
    ce && trig_mode == pmac_pkg::PMAC_EXT && st_q == pmac_pkg::PMAC_MEAS
      && in_act_q |=> st_q == pmac_pkg::PMAC_IDLE;
  endproperty
  a_ext: assert property (p_ext) else $error("ext stop ignored");

  c_alarm: cover property (@(posedge clk) disable iff (rst) $rose(alarm));
  c_seq: cover property (@(posedge clk) disable iff (rst)
    class_sequence && seq_idx_q == 5'h05);
  c_show: cover property (@(posedge clk) disable iff (rst)
    st_q == pmac_pkg::PMAC_SHOW);
endmodule : pmac_ctrl
`default_nettype wire

// [dv/pmac_plant.sv]
`default_nettype none
module pmac_plant
#(
  parameter int MIN_MEAS = 20
)
(
  // clock
  input wire logic clk,
  input wire logic rst,
  // request and answer delay
  input wire logic go,
  input wire logic [3:0] lag,
  // pin, low keeps the monitor stopped
  output logic start_n_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lag_q;
  logic [7:0] held_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      start_n_pin <= 1'h0;
      lag_q <= 4'h0;
      held_q <= 8'h00;
    end
    else if (!start_n_pin)
    begin
      lag_q <= go ? lag_q + 4'h1 : 4'h0;
      held_q <= 8'h00;
      if (go && lag_q >= lag)
        start_n_pin <= 1'h1;
    end
    else
    begin
      lag_q <= 4'h0;
      if (held_q != 8'hFF)
        held_q <= held_q + 8'h01;
      // short runs miss particles, so hold the pin up a minimum time
      if (!go && held_q >= 8'(MIN_MEAS))
        start_n_pin <= 1'h0;
    end
  end
endmodule : pmac_plant
`default_nettype wire

// [dv/testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, key_press, key_ack, activity, go;
  logic cleanup_watch, ack_hold, class_sequence, alt_standard;
  logic preset_flow_select, backlight_continuous, can_present, result_ready;
  logic [1:0] trig_mode, out_class, link_mode;
  logic [3:0] avg_count, lag;
  logic [4:0] ord_38_70, current_code;
  logic [15:0] meas_cyc, wait_cyc, pause_cyc, preset_flow, measured_flow;
  logic [15:0] flow_used;
  logic [19:0] thresholds, result_ord;
  logic start_n_pin, laser_adjust, measuring, result_shown, alarm, red_lamp;
  logic exclaim, flow_low_blink, flow_high_blink, backlight;
  logic route_serial, route_can;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  logic [4:0] exp_seq [6] = '{5'h1F, 5'h00, 5'h0D, 5'h19, 5'h1A, 5'h00};
  logic [2:0] rt [4] = '{3'h1, 3'h2, 3'h4, 3'h5};

  pmac_ctrl #(.DIM_CYC(50), .BLINK_BIT(2)) uut
  (
    .clk, .rst, .ce, .start_n_pin, .key_press, .key_ack, .activity,
    .trig_mode, .meas_cyc, .wait_cyc, .pause_cyc, .cleanup_watch, .ack_hold,
    .avg_count, .thresholds, .out_class, .class_sequence, .alt_standard,
    .preset_flow_select, .preset_flow, .backlight_continuous, .link_mode,
    .can_present, .result_ready, .result_ord, .ord_38_70, .measured_flow,
    .laser_adjust, .measuring, .result_shown, .alarm, .red_lamp, .exclaim,
    .current_code, .flow_used, .flow_low_blink, .flow_high_blink,
    .backlight, .route_serial, .route_can
  );

  pmac_plant #(.MIN_MEAS(20)) plant
  (
    .clk, .rst, .go, .lag, .start_n_pin
  );

  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  function automatic logic [19:0] pk(input logic [4:0] a, b, c, d);
    return {d, c, b, a};
  endfunction : pk

  function automatic logic pick(input int s);
    case (s)
      0: return laser_adjust;
      1: return measuring;
      2: return result_shown;
      default: return logic'(current_code === 5'h1F);
    endcase
  endfunction : pick

  // counts edges until the level shows, so it also measures lengths
  task automatic until_lvl(input int s, input logic lvl, input int lim,
                           output int c);
    c = 0;
    while (pick(s) !== lvl && c < lim)
    begin
      tick(1);
      c++;
    end
  endtask : until_lvl

  task automatic send(input logic [19:0] v);
    result_ord <= v;
    result_ready <= 1'h1;
    tick(1);
    result_ready <= 1'h0;
    tick(5);
  endtask : send

  task automatic alarm_is(input logic [19:0] v, input logic exp);
    send(v);
    check("alarm", 16'(alarm), 16'(exp));
    check("lamp", 16'({red_lamp, exclaim}), 16'({exp, exp}));
  endtask : alarm_is

  task automatic keys(input logic [2:0] k);
    {key_press, key_ack, activity} <= k;
    tick(1);
    {key_press, key_ack, activity} <= 3'h0;
    tick(5);
  endtask : keys

  // counts marker-high cycles over one full blink period of eight
  task automatic blinks(input logic [15:0] f, input int lo, input int hi);
    int a = 0;
    int b = 0;
    measured_flow <= f;
    tick(3);
    repeat (8)
    begin
      tick(1);
      a += int'(flow_low_blink);
      b += int'(flow_high_blink);
    end
    check("low blink", 16'(a), 16'(lo));
    check("high blink", 16'(b), 16'(hi));
  endtask : blinks

  initial
  begin
    {rst, ce, key_press, key_ack, activity, go} = 6'h30;
    {cleanup_watch, ack_hold, class_sequence, alt_standard} = 4'h0;
    {preset_flow_select, backlight_continuous, can_present} = 3'h0;
    {result_ready, trig_mode, out_class, link_mode} = 7'h00;
    {avg_count, lag, ord_38_70} = {4'h1, 4'h5, 5'h00};
    meas_cyc = 16'h0014;
    wait_cyc = 16'h000A;
    pause_cyc = 16'h001E;
    {preset_flow, measured_flow, thresholds, result_ord} = '0;
    tick(10);
    rst <= 1'h0;
    tick(2);
    check("backlight", 16'(backlight), 16'h0001);
    check("code", 16'(current_code), 16'h0000);
    thresholds <= pk(5'h0A, 5'h0C, 5'h00, 5'h00);
    alarm_is(pk(5'h0A, 5'h0C, 5'h1A, 5'h00), 1'h0);
    alarm_is(pk(5'h0A, 5'h0D, 5'h00, 5'h00), 1'h1);
    alarm_is(20'h0, 1'h1);
    thresholds <= pk(5'h1A, 5'h1A, 5'h00, 5'h00);
    keys(3'h2);
    check("alarm held", 16'(alarm), 16'h0001);
    thresholds <= pk(5'h0A, 5'h0C, 5'h00, 5'h00);
    alarm_is(pk(5'h01, 5'h01, 5'h01, 5'h01), 1'h0);
    thresholds <= 20'h0;
    alarm_is(pk(5'h1A, 5'h1A, 5'h1A, 5'h1A), 1'h0);
    cleanup_watch <= 1'h1;
    thresholds <= pk(5'h0A, 5'h0C, 5'h00, 5'h00);
    alarm_is(pk(5'h05, 5'h0D, 5'h00, 5'h00), 1'h0);
    alarm_is(pk(5'h05, 5'h0B, 5'h1A, 5'h1A), 1'h1);
    cleanup_watch <= 1'h0;
    ack_hold <= 1'h1;
    alarm_is(pk(5'h0B, 5'h01, 5'h01, 5'h01), 1'h1);
    alarm_is(pk(5'h01, 5'h01, 5'h01, 5'h01), 1'h1);
    keys(3'h2);
    check("alarm ack", 16'(alarm), 16'h0000);
    ack_hold <= 1'h0;
    avg_count <= 4'h2;
    alarm_is(pk(5'h02, 5'h01, 5'h01, 5'h01), 1'h0);
    alarm_is(pk(5'h02, 5'h01, 5'h01, 5'h01), 1'h0);
    alarm_is(pk(5'h12, 5'h01, 5'h01, 5'h01), 1'h0);
    alarm_is(pk(5'h12, 5'h01, 5'h01, 5'h01), 1'h1);
    avg_count <= 4'h1;
    alt_standard <= 1'h1;
    ord_38_70 <= 5'h14;
    out_class <= 2'h3;
    send(pk(5'h00, 5'h0D, 5'h19, 5'h03));
    check("folded", 16'(current_code), 16'h0014);
    alt_standard <= 1'h0;
    send(pk(5'h00, 5'h0D, 5'h19, 5'h1A));
    for (int g = 0; g < 4; g++)
    begin
      out_class <= 2'(g);
      tick(5);
      check("code", 16'(current_code), 16'(exp_seq[g + 1]));
    end
    class_sequence <= 1'h1;
    until_lvl(3, 1'h0, 2000, n);
    until_lvl(3, 1'h1, 2000, n);
    tick(128);
    foreach (exp_seq[i])
    begin
      check("sequence", 16'(current_code), 16'(exp_seq[i]));
      tick(256);
    end
    class_sequence <= 1'h0;
    preset_flow <= 16'h00C8;
    measured_flow <= 16'h0050;
    preset_flow_select <= 1'h1;
    tick(5);
    check("flow", flow_used, 16'h00C8);
    preset_flow_select <= 1'h0;
    tick(5);
    check("flow", flow_used, 16'h0050);
    blinks(16'h0050, 4, 0);
    blinks(16'h0064, 0, 0);
    blinks(16'h0190, 0, 0);
    blinks(16'h0191, 0, 4);
    for (int i = 0; i < 4; i++)
    begin
      {link_mode, can_present} <= rt[i];
      tick(5);
      check("route", 16'({route_serial, route_can}), 16'(2'h2 >> (i % 2)));
    end
    keys(3'h1);
    tick(45);
    check("light on", 16'(backlight), 16'h0001);
    tick(2);
    check("light off", 16'(backlight), 16'h0000);
    backlight_continuous <= 1'h1;
    tick(3);
    check("light kept", 16'(backlight), 16'h0001);
    until_lvl(1, 1'h1, 200, n);
    until_lvl(0, 1'h1, 200, n);
    until_lvl(0, 1'h0, 200, n);
    check("adjust len", 16'(n), 16'h0010);
    until_lvl(1, 1'h0, 200, n);
    check("measure len", 16'(n), 16'h0014);
    // five frozen edges must stretch the wait by exactly five
    ce <= 1'h0;
    tick(5);
    ce <= 1'h1;
    until_lvl(0, 1'h1, 200, n);
    check("wait len", 16'(n), 16'h000A);
    trig_mode <= 2'h1;
    tick(60);
    check("ext idle", 16'(measuring), 16'h0000);
    go <= 1'h1;
    until_lvl(0, 1'h1, 100, n);
    check("ext start", 16'(n), 16'h000D);
    until_lvl(0, 1'h0, 100, n);
    check("ext meas", 16'(measuring), 16'h0001);
    go <= 1'h0;
    until_lvl(1, 1'h0, 200, n);
    check("ext stop", 16'(n), 16'h0008);
    trig_mode <= 2'h2;
    keys(3'h4);
    until_lvl(1, 1'h1, 100, n);
    result_ord <= pk(5'h03, 5'h03, 5'h03, 5'h03);
    result_ready <= 1'h1;
    tick(1);
    result_ready <= 1'h0;
    until_lvl(2, 1'h1, 20, n);
    check("shown", 16'(result_shown), 16'h0001);
    until_lvl(1, 1'h1, 200, n);
    check("restart", 16'(n >= 30 && n < 200), 16'h0001);
    keys(3'h4);
    tick(30);
    check("key stop", 16'(measuring), 16'h0000);
    end_sim;
  end

  // cuts a hang well beyond the few thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim;
  end
endmodule : testbench
`default_nettype wire
